// [common/cau_pkg.sv]
// Package for the calendar alarm unit: constants, codes and state type
`default_nettype none
package cau_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int HALF_SEC_NS     = 500000000;
  localparam int HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;
  localparam int SYNC_CYCLES     = 32;
  localparam int PRESC_W         = 25;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADR_ALARM_WIN = 8'h00;
  localparam logic [7:0] ADR_ALARM_CFG = 8'h04;
  localparam logic [7:0] ADR_TIME_WIN  = 8'h08;
  localparam logic [7:0] ADR_CLOCK_CFG = 8'h0C;
  localparam logic [7:0] ADR_PAD_CFG   = 8'h10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ACR_EN   = 15;
  localparam int ACR_END  = 14;
  localparam int ACR_MHI  = 13;
  localparam int ACR_MLO  = 10;
  localparam int CCR_EN   = 15;
  localparam int CCR_UNL  = 13;
  localparam int CCR_SYN  = 12;
  localparam int CCR_HALF = 11;
  localparam int CCR_OE   = 10;
  localparam int PTR_HI   = 9;
  localparam int PTR_LO   = 8;
  localparam int PAD_SSEL = 1;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] ACR_RESET  = 16'h0000;
  localparam logic [15:0] CCR_RESET  = 16'h0000;
  localparam logic [15:0] PAD_RESET  = 16'h0000;
  localparam logic [7:0]  ZERO_BCD   = 8'h00;
  localparam logic [7:0]  FIRST_BCD  = 8'h01;
  // ----------------------------------------
  // Interval mask and window pointer codes
  // ----------------------------------------
  localparam logic [3:0] MASK_HALF_SEC = 4'h0;
  localparam logic [3:0] MASK_TEN_SEC  = 4'h2;
  localparam logic [3:0] MASK_MIN      = 4'h3;
  localparam logic [3:0] MASK_TEN_MIN  = 4'h4;
  localparam logic [3:0] MASK_HOUR     = 4'h5;
  localparam logic [3:0] MASK_DAY      = 4'h6;
  localparam logic [3:0] MASK_WEEK     = 4'h7;
  localparam logic [3:0] MASK_MONTH    = 4'h8;
  localparam logic [3:0] MASK_YEAR     = 4'h9;
  localparam logic [1:0] PTR_MIN_SEC   = 2'h0;
  localparam logic [1:0] PTR_WD_HR     = 2'h1;
  localparam logic [1:0] PTR_MON_DAY   = 2'h2;
  // ----------------------------------------
  // Module state
  // ----------------------------------------
  typedef struct packed {
    logic               ack;
    logic [15:0]        rdata;
    logic               alarm_enable;
    logic               endless_repeat;
    logic [3:0]         interval_mask;
    logic [1:0]         alarm_window_pointer;
    logic [7:0]         repeat_count;
    logic               calendar_enable;
    logic               time_write_unlock;
    logic               half_second_flag;
    logic               pin_output_enable;
    logic [1:0]         time_window_pointer;
    logic [7:0]         calibration;
    logic               seconds_output_select;
    logic [7:0]         sec;
    logic [7:0]         min;
    logic [7:0]         hour;
    logic [7:0]         wkday;
    logic [7:0]         day;
    logic [7:0]         month;
    logic [7:0]         year;
    logic [7:0]         al_sec;
    logic [7:0]         al_min;
    logic [7:0]         al_hour;
    logic [7:0]         al_wkday;
    logic [7:0]         al_day;
    logic [7:0]         al_month;
    logic [PRESC_W-1:0] presc;
    logic               eval_pending;
    logic               eval_full;
    logic               alarm_event;
    logic               alarm_pulse;
    logic               pin_out;
  } cau_state_s;
endpackage
`default_nettype wire

// [rtl/cau_top.sv]
// Calendar alarm unit with Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Issued alarm clears enable unless repeats remain
// - Interval mask selects compared alarm digits
// - Codes 0-3: half second to minute
// - Codes 4-9: minutes up to month compared
// - Zero count, no endless: one alarm
// - Repeat count eight bits, up to 255
// - Each alarm before the final one decrements the repeat count
// - Final alarm at zero, then enable clears
// - Endless repeat wraps count to FF
// - Every alarm event raises interrupt request
// - Alarm pulse toggles each event
// - Select bit picks alarm pulse or seconds
// - Alarm runs in sleep, wakes processor
// - Any reset clears alarm configuration
// - Clock configuration reset by power-on only
// - Prescaler cleared by seconds write or tick wrap, never by reset
// - Disabled module freezes, ignores writes
// - Alarm configuration register bit layout
// - Clock configuration register bit layout
// - Window access decrements pointer down to zero
// - Pointer selects alarm window pair
module cau_top #(
  parameter int HALF_SEC_CYCLES = cau_pkg::HALF_SEC_CYCLES,
  parameter int SYNC_CYCLES     = cau_pkg::SYNC_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        por,
  input  wire logic        module_disable_bit,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             alarm_irq,
  output logic             alarm_wake,
  output logic             clock_pin_out,
  output logic             clock_pin_oe
);
  import cau_pkg::*;

  // ----------------------------------------
  // Parameter checks and derived counts
  // ----------------------------------------
  if (HALF_SEC_CYCLES < 2 * SYNC_CYCLES || HALF_SEC_CYCLES > 2 ** PRESC_W || SYNC_CYCLES < 1)
  begin : g_bad
    $error("cau_top: unsupported prescaler parameters");
  end

  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(HALF_SEC_CYCLES - 1);
  localparam logic [PRESC_W-1:0] SYNC_START = PRESC_W'(HALF_SEC_CYCLES - SYNC_CYCLES);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    if (v == last)
      return first;
    if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    return v + 8'h01;
  endfunction

  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
           (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
    if (mon == 8'h02)
      return leap ? 8'h29 : 8'h28;
    if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
      return 8'h30;
    return 8'h31;
  endfunction

  function automatic logic [1:0] ptr_dec(input logic [1:0] p);
    return (p == 2'h0) ? 2'h0 : p - 2'h1;
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic en);
    return en ? nw : old;
  endfunction

  function automatic logic alarm_hit(input logic [3:0] m, input logic full,
                                     input cau_state_s s);
    logic ok;
    ok = 1'b1;
    if (m > MASK_YEAR)
      return 1'b0;
    if (m == MASK_HALF_SEC)
      return 1'b1;
    if (!full)
      return 1'b0;
    if (m >= MASK_TEN_SEC)
      ok = ok && (s.sec[3:0] == s.al_sec[3:0]);
    if (m >= MASK_MIN)
      ok = ok && (s.sec[7:4] == s.al_sec[7:4]);
    if (m >= MASK_TEN_MIN)
      ok = ok && (s.min[3:0] == s.al_min[3:0]);
    if (m >= MASK_HOUR)
      ok = ok && (s.min[7:4] == s.al_min[7:4]);
    if (m >= MASK_DAY)
      ok = ok && (s.hour == s.al_hour);
    if (m == MASK_WEEK)
      ok = ok && (s.wkday == s.al_wkday);
    if (m >= MASK_MONTH)
      ok = ok && (s.day == s.al_day);
    if (m == MASK_YEAR)
      ok = ok && (s.month == s.al_month);
    return ok;
  endfunction

  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  cau_state_s r;
  cau_state_s next_r;
  logic       acc;
  logic       wr;
  logic       tick;
  logic       hit;
  logic       sync_flag;
  logic       cfg_wr;
  logic       sec_carry;
  logic       min_carry;
  logic       hr_carry;
  logic       day_carry;
  logic       mon_carry;
  logic [7:0] lo;
  logic [7:0] hi;

  assign acc       = wb_cyc_i && wb_stb_i && !r.ack;
  assign wr        = acc && wb_we_i && !module_disable_bit;
  assign cfg_wr    = wr && (wb_adr_i == ADR_ALARM_CFG);
  assign lo        = wb_dat_i[7:0];
  assign hi        = wb_dat_i[15:8];
  assign tick      = r.calendar_enable && (r.presc == PRESC_LAST);
  assign hit       = alarm_hit(r.interval_mask, r.eval_full, r);
  assign sync_flag = r.calendar_enable && r.half_second_flag && (r.presc >= SYNC_START);
  assign sec_carry = r.sec == 8'h59;
  assign min_carry = sec_carry && r.min == 8'h59;
  assign hr_carry  = min_carry && r.hour == 8'h23;
  assign day_carry = hr_carry && r.day == month_last(r.month, r.year);
  assign mon_carry = day_carry && r.month == 8'h12;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_r             = r;
    next_r.ack         = acc;
    next_r.alarm_event = 1'b0;
    if (!module_disable_bit)
    begin
      // Prescaler and half-second tick
      if (r.calendar_enable)
        next_r.presc = tick ? '0 : r.presc + PRESC_W'(1);
      next_r.eval_pending = tick;
      next_r.eval_full    = tick && r.half_second_flag;
      if (tick)
      begin
        next_r.half_second_flag = !r.half_second_flag;
        if (r.half_second_flag)
        begin
          next_r.sec = bcd_step(r.sec, 8'h59, ZERO_BCD);
          if (sec_carry)
            next_r.min = bcd_step(r.min, 8'h59, ZERO_BCD);
          if (min_carry)
            next_r.hour = bcd_step(r.hour, 8'h23, ZERO_BCD);
          if (hr_carry)
            next_r.wkday = bcd_step(r.wkday, 8'h06, ZERO_BCD);
          if (hr_carry)
            next_r.day = bcd_step(r.day, month_last(r.month, r.year), FIRST_BCD);
          if (day_carry)
            next_r.month = bcd_step(r.month, 8'h12, FIRST_BCD);
          if (mon_carry)
            next_r.year = bcd_step(r.year, 8'h99, ZERO_BCD);
        end
      end
      // Alarm event and repeat counting
      if (r.eval_pending && r.alarm_enable && hit)
      begin
        next_r.alarm_event = 1'b1;
        next_r.alarm_pulse = !r.alarm_pulse;
        if (r.endless_repeat || r.repeat_count != 8'h00)
          next_r.repeat_count = r.repeat_count - 8'h01;
        else
          next_r.alarm_enable = 1'b0;
      end
      // Pin output
      next_r.pin_out = r.pin_output_enable &&
                       (r.seconds_output_select ? r.half_second_flag : r.alarm_pulse);
    end
    // Bus read data
    next_r.rdata = 16'h0000;
    if (acc && !module_disable_bit)
    begin
      unique case (wb_adr_i)
        ADR_ALARM_WIN:
          unique case (r.alarm_window_pointer)
            PTR_MIN_SEC: next_r.rdata = {r.al_min, r.al_sec};
            PTR_WD_HR:   next_r.rdata = {r.al_wkday, r.al_hour};
            PTR_MON_DAY: next_r.rdata = {r.al_month, r.al_day};
            default:     next_r.rdata = 16'h0000;
          endcase
        ADR_ALARM_CFG:
          next_r.rdata = {r.alarm_enable, r.endless_repeat, r.interval_mask,
                          r.alarm_window_pointer, r.repeat_count};
        ADR_TIME_WIN:
          unique case (r.time_window_pointer)
            PTR_MIN_SEC: next_r.rdata = {r.min, r.sec};
            PTR_WD_HR:   next_r.rdata = {r.wkday, r.hour};
            PTR_MON_DAY: next_r.rdata = {r.month, r.day};
            default:     next_r.rdata = {8'h00, r.year};
          endcase
        ADR_CLOCK_CFG:
          next_r.rdata = {r.calendar_enable, 1'b0, r.time_write_unlock, sync_flag,
                          r.half_second_flag, r.pin_output_enable, r.time_window_pointer,
                          r.calibration};
        ADR_PAD_CFG:
          next_r.rdata = {14'h0000, r.seconds_output_select, 1'b0};
        default:
          next_r.rdata = 16'h0000;
      endcase
    end
    // Bus writes, pointer stepping
    if (acc && !module_disable_bit)
    begin
      unique case (wb_adr_i)
        ADR_ALARM_WIN:
        begin
          next_r.alarm_window_pointer = ptr_dec(r.alarm_window_pointer);
          if (wr)
          begin
            unique case (r.alarm_window_pointer)
              PTR_MIN_SEC:
              begin
                next_r.al_min = merge(r.al_min, hi, wb_sel_i[1]);
                next_r.al_sec = merge(r.al_sec, lo, wb_sel_i[0]);
              end
              PTR_WD_HR:
              begin
                next_r.al_wkday = merge(r.al_wkday, hi, wb_sel_i[1]);
                next_r.al_hour  = merge(r.al_hour, lo, wb_sel_i[0]);
              end
              PTR_MON_DAY:
              begin
                next_r.al_month = merge(r.al_month, hi, wb_sel_i[1]);
                next_r.al_day   = merge(r.al_day, lo, wb_sel_i[0]);
              end
              default:
                next_r.al_day = r.al_day;
            endcase
          end
        end
        ADR_ALARM_CFG:
          if (wr)
          begin
            if (wb_sel_i[1])
            begin
              next_r.alarm_enable         = hi[ACR_EN-8];
              next_r.endless_repeat       = hi[ACR_END-8];
              next_r.interval_mask        = hi[ACR_MHI-8:ACR_MLO-8];
              next_r.alarm_window_pointer = hi[PTR_HI-8:PTR_LO-8];
            end
            if (wb_sel_i[0])
              next_r.repeat_count = lo;
          end
        ADR_TIME_WIN:
        begin
          next_r.time_window_pointer = ptr_dec(r.time_window_pointer);
          if (wr && r.time_write_unlock)
          begin
            unique case (r.time_window_pointer)
              PTR_MIN_SEC:
              begin
                next_r.min = merge(next_r.min, hi, wb_sel_i[1]);
                if (wb_sel_i[0])
                begin
                  next_r.sec              = lo;
                  next_r.presc            = '0;
                  next_r.half_second_flag = 1'b0;
                end
              end
              PTR_WD_HR:
              begin
                next_r.wkday = merge(next_r.wkday, hi, wb_sel_i[1]);
                next_r.hour  = merge(next_r.hour, lo, wb_sel_i[0]);
              end
              PTR_MON_DAY:
              begin
                next_r.month = merge(next_r.month, hi, wb_sel_i[1]);
                next_r.day   = merge(next_r.day, lo, wb_sel_i[0]);
              end
              default:
                next_r.year = merge(next_r.year, lo, wb_sel_i[0]);
            endcase
          end
        end
        ADR_CLOCK_CFG:
          if (wr)
          begin
            if (wb_sel_i[1])
            begin
              next_r.calendar_enable     = hi[CCR_EN-8];
              next_r.time_write_unlock   = hi[CCR_UNL-8];
              next_r.pin_output_enable   = hi[CCR_OE-8];
              next_r.time_window_pointer = hi[PTR_HI-8:PTR_LO-8];
            end
            if (wb_sel_i[0])
              next_r.calibration = lo;
          end
        ADR_PAD_CFG:
          if (wr && wb_sel_i[0])
            next_r.seconds_output_select = lo[PAD_SSEL];
        default:
          next_r.rdata = 16'h0000;
      endcase
    end
    // Resets; prescaler is left alone by both
    if (rst || por)
    begin
      {next_r.alarm_enable, next_r.endless_repeat, next_r.interval_mask,
       next_r.alarm_window_pointer, next_r.repeat_count} = ACR_RESET;
      next_r.seconds_output_select = PAD_RESET[PAD_SSEL];
      next_r.ack          = 1'b0;
      next_r.rdata        = 16'h0000;
      next_r.eval_pending = 1'b0;
      next_r.eval_full    = 1'b0;
      next_r.alarm_event  = 1'b0;
      next_r.alarm_pulse  = 1'b0;
      next_r.pin_out      = 1'b0;
    end
    if (por)
    begin
      next_r.calendar_enable     = CCR_RESET[CCR_EN];
      next_r.time_write_unlock   = CCR_RESET[CCR_UNL];
      next_r.half_second_flag    = CCR_RESET[CCR_HALF];
      next_r.pin_output_enable   = CCR_RESET[CCR_OE];
      next_r.time_window_pointer = CCR_RESET[PTR_HI:PTR_LO];
      next_r.calibration         = CCR_RESET[7:0];
      {next_r.sec, next_r.min, next_r.hour, next_r.wkday, next_r.year} = {5{ZERO_BCD}};
      {next_r.day, next_r.month} = {2{FIRST_BCD}};
      {next_r.al_sec, next_r.al_min, next_r.al_hour, next_r.al_wkday} = {4{ZERO_BCD}};
      {next_r.al_day, next_r.al_month} = {2{FIRST_BCD}};
    end
  end

  always_ff @(posedge clk)
  begin
    r <= next_r;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_ack_o      = r.ack;
  assign wb_dat_o      = {16'h0000, r.rdata};
  assign alarm_irq     = r.alarm_event;
  assign alarm_wake    = r.alarm_event;
  assign clock_pin_out = r.pin_out;
  assign clock_pin_oe  = r.pin_output_enable;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || por);

  sequence s_fire;
    r.eval_pending && r.alarm_enable && hit && !module_disable_bit;
  endsequence

  sequence s_last_fire;
    s_fire ##0 (!r.endless_repeat && r.repeat_count == 8'h00 && !cfg_wr);
  endsequence

  chk_match_fires: assert property (s_fire |=> r.alarm_event)
    else $error("match did not raise alarm");
  chk_event_cause: assert property (r.alarm_event |-> $past(r.eval_pending && r.alarm_enable))
    else $error("alarm without evaluation");
  chk_event_single: assert property (r.alarm_event |=> !r.alarm_event [*2])
    else $error("alarm repeated within tick");
  chk_last_clears: assert property (s_last_fire |=> !r.alarm_enable)
    else $error("enable not cleared after final alarm");
  chk_count_dec: assert property (s_fire ##0 (r.repeat_count != 8'h00 && !cfg_wr)
                                  |=> r.repeat_count == $past(r.repeat_count) - 8'h01
                                      && r.alarm_enable)
    else $error("repeat count not decremented");
  chk_endless_wrap: assert property (s_fire ##0 (r.endless_repeat && r.repeat_count == 8'h00
                                     && !cfg_wr) |=> r.repeat_count == 8'hFF && r.alarm_enable)
    else $error("endless repeat did not wrap");
  chk_pulse_toggle: assert property (r.alarm_event |-> r.alarm_pulse != $past(r.alarm_pulse))
    else $error("alarm pulse did not toggle");
  chk_pin_select: assert property (r.pin_output_enable && r.seconds_output_select
                                   && !module_disable_bit |=> r.pin_out == $past(r.half_second_flag))
    else $error("seconds clock not on pin");
  chk_pin_gate: assert property (!r.pin_output_enable |=> !r.pin_out)
    else $error("pin active while disabled");
  chk_disable_hold: assert property (module_disable_bit |=> $stable(r.repeat_count)
                                     && $stable(r.sec) && $stable(r.presc))
    else $error("state moved while module disabled");
  chk_ptr_step: assert property (acc && !module_disable_bit && wb_adr_i == ADR_ALARM_WIN
                                 |=> r.alarm_window_pointer == ptr_dec($past(r.alarm_window_pointer)))
    else $error("alarm pointer did not step");
  chk_cfg_reset: assert property (@(posedge clk) disable iff (1'b0)
                                  (rst || por) |=> !r.alarm_enable && r.repeat_count == 8'h00)
    else $error("alarm configuration not cleared by reset");
  chk_ccr_keep: assert property (@(posedge clk) disable iff (por)
                                 rst && !wr |=> r.calendar_enable == $past(r.calendar_enable))
    else $error("clock configuration lost on ordinary reset");
endmodule
`default_nettype wire

// [sim/tb_cau_top.sv]
// Self-checking testbench for the calendar alarm unit
`timescale 1ns/1ps
`default_nettype none
module tb_cau_top;
  import cau_pkg::*;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic        clk = 0, rst = 1, por = 1, mdis = 0;
  logic        cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, wb_dat_o;
  logic        wb_ack_o, alarm_irq, alarm_wake, clock_pin_out, clock_pin_oe, pin_q = 0;
  int          err_total = 0, check_count = 0, irq_n = 0, wake_n = 0, tog_n = 0;
  cau_top #(.HALF_SEC_CYCLES(100), .SYNC_CYCLES(4)) cau_top_inst (
    .clk(clk), .rst(rst), .por(por), .module_disable_bit(mdis),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alarm_irq(alarm_irq),
    .alarm_wake(alarm_wake), .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe));
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    if (alarm_irq === 1'b1) irq_n <= irq_n + 1;
    if (alarm_wake === 1'b1) wake_n <= wake_n + 1;
    if (clock_pin_out !== pin_q) tog_n <= tog_n + 1;
    pin_q <= clock_pin_out;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [15:0] d, output logic [15:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= s; wdat <= {16'h0000, d};
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 50)
    begin
      err_total++;
      complete_run();
    end
    r = wb_dat_o[15:0];
    cyc <= 0; stb <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    wb(1'b1, a, 4'hF, d, r);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] m,
                        input logic [15:0] e);
    logic [15:0] r;
    wb(1'b0, a, 4'hF, 16'h0000, r);
    chk(nm, e, r & m);
  endtask
  task automatic acfg_wr(input logic [15:0] d);
    logic [15:0] r;
    int          n;
    n = 0;
    r = 16'h1000;
    while (r[CCR_SYN] && n < 20)
    begin
      wb(1'b0, ADR_CLOCK_CFG, 4'hF, 16'h0000, r);
      n++;
    end
    if (r[CCR_SYN])
    begin
      err_total++;
      complete_run();
    end
    wr(ADR_ALARM_CFG, d);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [3:0] mk [5];
    int         win [5], exp_n [5], i0, w0, t0, n;
    mk = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA};
    win = '{1000, 1000, 4000, 12000, 2000};
    exp_n = '{10, 5, 2, 1, 0};
    repeat (16) @(posedge clk);
    rst <= 0; por <= 0;
    rd_chk("alarm_cfg", ADR_ALARM_CFG, 16'hFFFF, ACR_RESET);
    rd_chk("clock_cfg", ADR_CLOCK_CFG, 16'hFFFF, CCR_RESET);
    rd_chk("pad_cfg", ADR_PAD_CFG, 16'hFFFF, PAD_RESET);
    rd_chk("unmapped", 8'h14, 16'hFFFF, 16'h0000);
    $display("Test reset values done");
    wr(ADR_ALARM_CFG, 16'h0200);
    rd_chk("win_mon_day", ADR_ALARM_WIN, 16'hFFFF, 16'h0101);
    rd_chk("ptr_step", ADR_ALARM_CFG, 16'hFFFF, 16'h0100);
    rd_chk("win_wd_hr", ADR_ALARM_WIN, 16'hFFFF, 16'h0000);
    rd_chk("win_min_sec", ADR_ALARM_WIN, 16'hFFFF, 16'h0000);
    rd_chk("ptr_floor", ADR_ALARM_CFG, 16'hFFFF, 16'h0000);
    $display("Test alarm pointer done");
    wr(ADR_CLOCK_CFG, 16'h2000);
    begin
      logic [15:0] r;
      wb(1'b1, ADR_TIME_WIN, 4'h1, 16'h0000, r);
    end
    wr(ADR_CLOCK_CFG, 16'hA400);
    mdis <= 1;
    wr(ADR_PAD_CFG, 16'h0002);
    rd_chk("disabled_rd", ADR_PAD_CFG, 16'hFFFF, 16'h0000);
    mdis <= 0;
    rd_chk("pad_after", ADR_PAD_CFG, 16'hFFFF, 16'h0000);
    $display("Test module disable done");
    i0 = irq_n; w0 = wake_n; t0 = tog_n;
    acfg_wr(16'h8002);
    repeat (600) @(posedge clk);
    chk("irq_count", 16'd3, 16'(irq_n - i0));
    chk("wake_count", 16'd3, 16'(wake_n - w0));
    chk("pin_toggles", 16'd3, 16'(tog_n - t0));
    chk("pin_oe", 16'h0001, {15'h0, clock_pin_oe});
    rd_chk("auto_off", ADR_ALARM_CFG, 16'hFFFF, 16'h0000);
    $display("Test repeat count done");
    for (int k = 0; k < 5; k++)
    begin
      acfg_wr({2'b11, mk[k], 10'h000});
      @(posedge clk);
      i0 = irq_n;
      repeat (win[k]) @(posedge clk);
      chk("mask_rate", 16'(exp_n[k]), 16'(irq_n - i0));
    end
    $display("Test interval masks done");
    acfg_wr(16'hC000);
    n = 0;
    while (alarm_irq !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk("irq_wait", 16'h0001, {15'h0, n < 300});
    if (n >= 300)
      complete_run();
    rd_chk("endless_wrap", ADR_ALARM_CFG, 16'hFFFF, 16'hC0FF);
    $display("Test endless repeat done");
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd_chk("rst_alarm", ADR_ALARM_CFG, 16'hFFFF, 16'h0000);
    rd_chk("rst_clock", ADR_CLOCK_CFG, 16'hE700, 16'hA400);
    $display("Test ordinary reset done");
    wr(ADR_PAD_CFG, 16'h0002);
    rd_chk("pad_sel", ADR_PAD_CFG, 16'hFFFF, 16'h0002);
    repeat (3) @(posedge clk);
    t0 = tog_n;
    repeat (400) @(posedge clk);
    chk("sec_toggles", 16'h0004, 16'(tog_n - t0));
    $display("Test seconds output done");
    complete_run();
  end
endmodule
`default_nettype wire
